// ---- hdl/eeprom_pins.sv ----
// serial eeprom pin protocol core with apb register access
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_pins_defs.svh"

// Overview of operation
// - output bit launched on sck falling edge, changes only after it.
// - input bits sampled on each sck rising edge while selected and not paused.
// - select high deselects the device and floats the serial output.
// - deselected means standby unless a self-timed write runs; select low activates.
// - active-low pause suspends transfer without deselecting; transfer resumes later.
// - during pause output floats, serial input and clock are ignored.
// - write-protect input freezes the protected area size from the area lock bits.
// - link runs clock mode 0 or 3, data sampled on rising edge.
// - busy flag reads 1 for the whole self-timed write, then 0.
// - lock enable 1 with write-protect low makes protect bits read-only.
module eeprom_pins
#(
  parameter int ADDR_W       = 8,
  parameter int WRITE_CYCLES = `WRITE_CYCLES
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe_n,
  output logic                   standby,
  output logic                   busy_flag
);
  import eeprom_pins_pkg::*;

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

  link_xfer_if xfer ();

  logic             cs_meta_reg;
  logic             cs_sync_reg;
  logic             cs_prev_reg;
  logic             hold_meta_reg;
  logic             hold_sync_reg;
  logic             wp_meta_reg;
  logic             wp_sync_reg;
  logic             rx_meta_reg;
  logic             rx_sync_reg;
  logic             rx_last_reg;
  logic             ack_meta_reg;
  logic             ack_sync_reg;
  logic             ack_last_reg;

  logic             armed_reg;
  byte_t            rx_data_reg;
  logic             rx_valid_reg;
  logic             rx_overrun_reg;
  byte_t            tx_data_reg;
  logic             tx_pending_reg;
  logic             area_lock_low_bit_reg;
  logic             area_lock_high_bit_reg;
  logic             lock_enable_flag_reg;
  logic [2:0]       stage_reg;
  logic             commit_ok_reg;
  wcyc_t            wc_state_reg;
  wcyc_t            wc_state_next;
  logic [CNT_W-1:0] wc_cnt_reg;
  logic             pready_reg;
  logic [31:0]      prdata_reg;
  logic             pslverr_reg;
  logic             standby_reg;
  logic             busy_flag_reg;

  logic             wr_en;
  logic             rd_en;
  logic             rx_event;
  logic             ack_event;
  logic             cs_fall;
  logic             hw_protected;
  logic             go;
  logic             rx_read;
  logic [31:0]      status_word;
  logic [31:0]      rd_next;
  logic             err_next;

  spi_link u_link
  (
    .presetn (presetn),
    .sck     (sck),
    .cs_n    (cs_n),
    .si      (si),
    .hold_n  (hold_n),
    .so      (so),
    .so_oe_n (so_oe_n),
    .lx      (xfer.link)
  );

  assign xfer.tx_byte = tx_data_reg;

  // pins and link toggles pass two flops before anything reads them;
  // select resets to low so a select held low through reset is no edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_meta_reg   <= 1'b0;
      cs_sync_reg   <= 1'b0;
      cs_prev_reg   <= 1'b0;
      hold_meta_reg <= 1'b1;
      hold_sync_reg <= 1'b1;
      wp_meta_reg   <= 1'b0;
      wp_sync_reg   <= 1'b0;
    end
    else
    begin
      cs_meta_reg   <= cs_n;
      cs_sync_reg   <= cs_meta_reg;
      cs_prev_reg   <= cs_sync_reg;
      hold_meta_reg <= hold_n;
      hold_sync_reg <= hold_meta_reg;
      wp_meta_reg   <= wp_n;
      wp_sync_reg   <= wp_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg  <= 1'b0;
      rx_sync_reg  <= 1'b0;
      rx_last_reg  <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_last_reg <= 1'b0;
    end
    else
    begin
      rx_meta_reg  <= xfer.rx_tgl;
      rx_sync_reg  <= rx_meta_reg;
      rx_last_reg  <= rx_sync_reg;
      ack_meta_reg <= xfer.tx_ack_tgl;
      ack_sync_reg <= ack_meta_reg;
      ack_last_reg <= ack_sync_reg;
    end
  end

  assign rx_event     = rx_sync_reg ^ rx_last_reg;
  assign ack_event    = ack_sync_reg ^ ack_last_reg;
  assign cs_fall      = cs_prev_reg & ~cs_sync_reg;
  assign hw_protected = lock_enable_flag_reg & ~wp_sync_reg;

  // apb access phase completes in the cycle pready is high
  assign wr_en   = psel & penable & pwrite & pready_reg;
  assign rd_en   = psel & penable & ~pwrite & pready_reg;
  assign go      = wr_en && paddr == ADDR_W'(`OFF_CTRL)
                   && pwdata[`CTRL_GO];
  assign rx_read = rd_en && paddr == ADDR_W'(`OFF_RXDATA);

  // no received byte counts until select has fallen once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_reg <= 1'b0;
    else if (cs_fall)
      armed_reg <= 1'b1;
  end

  // received byte: arrival beats a read that clears in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data_reg    <= 8'h00;
      rx_valid_reg   <= 1'b0;
      rx_overrun_reg <= 1'b0;
    end
    else if (rx_event && armed_reg)
    begin
      rx_data_reg    <= xfer.rx_byte;
      rx_valid_reg   <= 1'b1;
      rx_overrun_reg <= rx_overrun_reg | (rx_valid_reg & ~rx_read);
    end
    else if (rx_read)
    begin
      rx_valid_reg   <= 1'b0;
      rx_overrun_reg <= 1'b0;
    end
  end

  // the link reads tx_data_reg unsynchronised when it loads a byte;
  // software must only rewrite it while tx_pending is clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_data_reg    <= `TXDATA_RST;
      tx_pending_reg <= 1'b0;
    end
    else if (wr_en && paddr == ADDR_W'(`OFF_TXDATA))
    begin
      tx_data_reg    <= pwdata[7:0];
      tx_pending_reg <= 1'b1;
    end
    else if (ack_event)
      tx_pending_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_reg <= `STAGE_RST;
    else if (wr_en && paddr == ADDR_W'(`OFF_STAGE))
      stage_reg <= {pwdata[`SR_LOCK_EN], pwdata[`SR_AREA_HI],
                    pwdata[`SR_AREA_LO]};
  end

  // self-timed write: starts at deselect, runs the full write time
  always_comb
  begin
    wc_state_next = wc_state_reg;
    unique case (wc_state_reg)
      WC_IDLE:
        if (go)
          wc_state_next = cs_sync_reg ? WC_BUSY : WC_WAIT;
      WC_WAIT:
        if (cs_sync_reg)
          wc_state_next = WC_BUSY;
      WC_BUSY:
        if (wc_cnt_reg == '0)
          wc_state_next = WC_IDLE;
      default:
        wc_state_next = WC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wc_state_reg <= WC_IDLE;
    else
      wc_state_reg <= wc_state_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wc_cnt_reg <= '0;
    else if (wc_state_reg != WC_BUSY)
      wc_cnt_reg <= CNT_LOAD;
    else if (wc_cnt_reg != '0)
      wc_cnt_reg <= wc_cnt_reg - CNT_W'(1);
  end

  // protection checked when the cycle is requested and again at its end, applied at its end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      commit_ok_reg <= 1'b0;
    else if (wc_state_reg == WC_IDLE && go)
      commit_ok_reg <= ~hw_protected;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      area_lock_low_bit_reg  <= 1'b0;
      area_lock_high_bit_reg <= 1'b0;
      lock_enable_flag_reg   <= 1'b0;
    end
    else if (wc_state_reg == WC_BUSY && wc_cnt_reg == '0
             && commit_ok_reg && !hw_protected)
    begin
      area_lock_low_bit_reg  <= stage_reg[0];
      area_lock_high_bit_reg <= stage_reg[1];
      lock_enable_flag_reg   <= stage_reg[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_flag_reg <= 1'b0;
      standby_reg   <= 1'b0;
    end
    else
    begin
      busy_flag_reg <= (wc_state_next == WC_BUSY);
      standby_reg   <= cs_sync_reg && wc_state_next != WC_BUSY;
    end
  end

  always_comb
  begin
    status_word                 = 32'h0000_0000;
    status_word[`SR_BUSY]       = busy_flag_reg;
    status_word[`SR_AREA_LO]    = area_lock_low_bit_reg;
    status_word[`SR_AREA_HI]    = area_lock_high_bit_reg;
    status_word[`SR_LOCK_EN]    = lock_enable_flag_reg;
    status_word[`SR_HW_PROT]    = hw_protected;
    status_word[`SR_WP_LEVEL]   = wp_sync_reg;
    status_word[`SR_ARMED]      = armed_reg;
    status_word[`SR_DESELECTED] = cs_sync_reg;
    // pause seen only while selected; a pause while deselected is void
    status_word[`SR_PAUSED]     = ~hold_sync_reg & ~cs_sync_reg;
    status_word[`SR_STANDBY]    = standby_reg;
    status_word[`SR_RX_VALID]   = rx_valid_reg;
    status_word[`SR_RX_OVERRUN] = rx_overrun_reg;
    status_word[`SR_TX_PENDING] = tx_pending_reg;
  end

  always_comb
  begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == ADDR_W'(`OFF_CTRL))
      rd_next = 32'h0000_0000;
    else if (paddr == ADDR_W'(`OFF_STATUS))
      rd_next = status_word;
    else if (paddr == ADDR_W'(`OFF_STAGE))
    begin
      rd_next[`SR_AREA_LO] = stage_reg[0];
      rd_next[`SR_AREA_HI] = stage_reg[1];
      rd_next[`SR_LOCK_EN] = stage_reg[2];
    end
    else if (paddr == ADDR_W'(`OFF_RXDATA))
      rd_next[7:0] = rx_data_reg;
    else if (paddr == ADDR_W'(`OFF_TXDATA))
      rd_next[7:0] = tx_data_reg;
    else
      err_next = 1'b1;
  end

  // answers prepared in the setup cycle, so no wait states are inserted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & ~penable;
      if (psel && !penable)
      begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr_reg <= err_next;
      end
      else
      begin
        prdata_reg  <= 32'h0000_0000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign standby   = standby_reg;
  assign busy_flag = busy_flag_reg;
endmodule
`default_nettype wire

// ---- hdl/eeprom_pins_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef EEPROM_PINS_DEFS_SVH
`define EEPROM_PINS_DEFS_SVH

`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_STAGE      8'h08
`define OFF_RXDATA     8'h0C
`define OFF_TXDATA     8'h10

`define CTRL_GO        0
`define SR_BUSY        0
`define SR_AREA_LO     2
`define SR_AREA_HI     3
`define SR_LOCK_EN     7
`define SR_HW_PROT     8
`define SR_WP_LEVEL    9
`define SR_ARMED       10
`define SR_DESELECTED  11
`define SR_PAUSED      12
`define SR_STANDBY     13
`define SR_RX_VALID    14
`define SR_RX_OVERRUN  15
`define SR_TX_PENDING  16

`define STAGE_RST      3'h0
`define TXDATA_RST     8'h00

`define PCLK_PERIOD_NS 40
`define WRITE_TIME_MS  5
`define WRITE_CYCLES   ((`WRITE_TIME_MS * 1000000) / `PCLK_PERIOD_NS)

`endif

// ---- hdl/eeprom_pins_pkg.sv ----
// types shared by the serial eeprom pin block
package eeprom_pins_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0]
  {
    WC_IDLE = 3'b001,
    WC_WAIT = 3'b010,
    WC_BUSY = 3'b100
  } wcyc_t;

endpackage

// ---- hdl/link_xfer_if.sv ----
// byte hand-off between the shift-clock logic and the bus-clock core
`timescale 1ns/1ps
`default_nettype none
interface link_xfer_if;
  import eeprom_pins_pkg::*;

  byte_t rx_byte;
  logic  rx_tgl;
  byte_t tx_byte;
  logic  tx_ack_tgl;

  modport core
  (
    input  rx_byte,
    input  rx_tgl,
    output tx_byte,
    input  tx_ack_tgl
  );

  modport link
  (
    output rx_byte,
    output rx_tgl,
    input  tx_byte,
    output tx_ack_tgl
  );
endinterface
`default_nettype wire

// ---- hdl/spi_link.sv ----
// shift-clock domain: bit capture, bit launch and output enable
`timescale 1ns/1ps
`default_nettype none
module spi_link
(
  input  wire logic   presetn,
  input  wire logic   sck,
  input  wire logic   cs_n,
  input  wire logic   si,
  input  wire logic   hold_n,
  output logic        so,
  output logic        so_oe_n,
  link_xfer_if.link   lx
);
  import eeprom_pins_pkg::*;

  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic       byte_done_reg;
  byte_t      tx_shift_reg;
  logic       paused;
  logic       quiet;
  logic       drive_reg;

  // hold only changes while sck is low, so gating edges by its level is safe
  assign paused = ~hold_n;
  assign quiet  = cs_n | paused;

  // capture on rising edges; either idle level of sck works
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 7'h00;
      byte_done_reg <= 1'b0;
    end
    else if (!paused)
    begin
      shift_reg     <= {shift_reg[5:0], si};
      bit_cnt_reg   <= bit_cnt_reg + 3'h1;
      byte_done_reg <= (bit_cnt_reg == 3'h7);
    end
  end

  // byte and toggle survive deselect so the core never sees a false event
  always_ff @(posedge sck or negedge presetn)
  begin
    if (!presetn)
    begin
      lx.rx_byte <= 8'h00;
      lx.rx_tgl  <= 1'b0;
    end
    else if (!cs_n && !paused && bit_cnt_reg == 3'h7)
    begin
      lx.rx_byte <= {shift_reg, si};
      lx.rx_tgl  <= ~lx.rx_tgl;
    end
  end

  // launch on falling edges; a new byte loads after each full byte in
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
      tx_shift_reg <= 8'h00;
    else if (!paused)
    begin
      if (byte_done_reg)
        tx_shift_reg <= lx.tx_byte;
      else
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  always_ff @(negedge sck or negedge presetn)
  begin
    if (!presetn)
      lx.tx_ack_tgl <= 1'b0;
    else if (!cs_n && !paused && byte_done_reg)
      lx.tx_ack_tgl <= ~lx.tx_ack_tgl;
  end

  // driver armed on a falling edge and kept across a pause
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
      drive_reg <= 1'b0;
    else if (!paused)
      drive_reg <= 1'b1;
  end

  // level gating instead of a pure flop: a pause ends with sck low, so the
  // driver must come back without waiting for another falling edge
  assign so_oe_n = quiet | ~drive_reg;

  assign so = tx_shift_reg[7];
endmodule
`default_nettype wire

// ---- verification/eeprom_pins_props.sv ----
// concurrent checks on the serial pin behaviour of the eeprom block
`timescale 1ns/1ps
`default_nettype none
module eeprom_pins_props
#(
  parameter int WRITE_CYCLES = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic standby,
  input wire logic busy_flag
);
  logic [31:0] busy_cnt;
  logic        so_at_rise;
  // the write cycle is far too long for a repetition, so count it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_cnt <= '0;
    else if (busy_flag)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= '0;
  end
  always_ff @(posedge sck)
  begin
    so_at_rise <= so;
  end
  sequence s_paused;
    (!hold_n && !cs_n) ##1 (!hold_n && !cs_n);
  endsequence
  chk_deselect_floats: assert property (@(posedge pclk)
    disable iff (!presetn) cs_n |-> so_oe_n)
    else $error("output driven while deselected");
  chk_pause_floats: assert property (@(posedge pclk)
    disable iff (!presetn) !hold_n |-> so_oe_n)
    else $error("output driven during pause");
  chk_launch_on_fall: assert property (@(negedge sck)
    disable iff (!presetn || cs_n) !so_oe_n |-> so == so_at_rise)
    else $error("output moved while clock high");
  chk_pause_keeps_out: assert property (@(posedge pclk)
    disable iff (!presetn) s_paused |-> $stable(so))
    else $error("output moved during pause");
  chk_select_wakes: assert property (@(posedge pclk)
    disable iff (!presetn) !cs_n [*5] |-> !standby)
    else $error("standby while selected");
  chk_idle_sleeps: assert property (@(posedge pclk)
    disable iff (!presetn) (cs_n && !busy_flag) [*8] |-> standby)
    else $error("no standby while idle");
  chk_busy_awake: assert property (@(posedge pclk)
    disable iff (!presetn) $past(busy_flag) && busy_flag |-> !standby)
    else $error("standby during write cycle");
  chk_busy_length: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(busy_flag) |-> busy_cnt == WRITE_CYCLES)
    else $error("write cycle length wrong");
  chk_busy_bounded: assert property (@(posedge pclk)
    disable iff (!presetn) busy_flag |-> busy_cnt < WRITE_CYCLES)
    else $error("write cycle overran");
endmodule
bind eeprom_pins eeprom_pins_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props
(
  .pclk(pclk), .presetn(presetn), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
  .so(so), .so_oe_n(so_oe_n), .standby(standby), .busy_flag(busy_flag)
);
`default_nettype wire

// ---- verification/eeprom_pins_test.sv ----
// self-checking bench for the serial eeprom pin block
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_pins_defs.svh"
module eeprom_pins_test;
  import eeprom_pins_pkg::*;
  localparam int WC = 20;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wp_n;
  logic        sck, cs_n, si, hold_n, so, so_oe_n, standby, busy_flag;
  logic [31:0] rdat;
  logic        rerr;
  byte_t       r;
  int          errors;
  int          samples_checked;
  int          cyc;
  always #20 pclk = ~pclk;
  eeprom_pins #(.ADDR_W(8), .WRITE_CYCLES(WC)) dut
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
    .standby(standby), .busy_flag(busy_flag)
  );
  spi_host_model host
  (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe_n(so_oe_n)
  );
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_rx(input byte_t exp);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `OFF_STATUS, 32'h0);
      n++;
    end
    while (rdat[`SR_RX_VALID] !== 1'b1 && n < 20);
    apb(1'b0, `OFF_RXDATA, 32'h0);
    chk(rdat, {24'h0, exp});
  endtask
  task automatic t_power_up();
    host.xfer(8'h5A, -1, r);
    repeat (8) @(posedge pclk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rdat[`SR_RX_VALID], 1'b0);
    chk(rdat[`SR_ARMED], 1'b0);
    host.desel();
  endtask
  task automatic t_regs();
    repeat (4) @(posedge pclk);
    chk({standby, so_oe_n}, 2'b11);
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
  endtask
  task automatic t_bytes(input logic m3);
    byte_t tx;
    tx = m3 ? 8'h96 : 8'h3C;
    apb(1'b1, `OFF_TXDATA, {24'h0, tx});
    host.sel(m3);
    host.xfer(~tx, -1, r);
    rd_rx(~tx);
    chk(standby, 1'b0);
    host.xfer(8'hA5, -1, r);
    chk(r, tx);
    rd_rx(8'hA5);
    host.desel();
  endtask
  // pause in mid-byte while the output is driven; both ways must resume
  task automatic t_pause();
    apb(1'b1, `OFF_TXDATA, 32'hB4);
    host.sel(1'b0);
    host.xfer(8'h11, -1, r);
    rd_rx(8'h11);
    host.xfer(8'hE7, 3, r);
    chk(r, 8'hB4);
    rd_rx(8'hE7);
    host.desel();
  endtask
  task automatic prot_step(input logic wp, input logic [31:0] stg, exp,
                           input logic len);
    int n;
    wp_n <= wp;
    apb(1'b1, `OFF_STAGE, stg);
    apb(1'b1, `OFF_CTRL, 32'h1);
    n = 0;
    while (busy_flag !== 1'b1 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (busy_flag === 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    if (len)
      chk(n, WC);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rdat & 32'h18C, exp);
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wp_n = 1'b1;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    // select falls inside reset, so the first byte must be dropped
    fork
      host.sel(1'b0);
      repeat (6) @(posedge pclk);
    join
    presetn <= 1'b1;
    t_power_up();
    t_regs();
    t_bytes(1'b0);
    t_bytes(1'b1);
    t_pause();
    prot_step(1'b1, 32'h8C, 32'h08C, 1'b1);
    prot_step(1'b0, 32'h00, 32'h18C, 1'b0);
    prot_step(1'b1, 32'h00, 32'h000, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- verification/spi_host_model.sv ----
// host side model: drives the serial link in clock mode 0 or 3
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  output var logic hold_n,
  input  wire logic so,
  input  wire logic so_oe_n
);
  import eeprom_pins_pkg::*;
  localparam realtime HALF = 62.5;
  logic cpol;
  // a floating output is seen as the inverse of its last value
  wire  q = so_oe_n ? ~so : so;
  initial
  begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    // one select pulse gives the link flops a defined start
    #10;
    cs_n = 1'b1;
  end
  task automatic sel(input logic m3);
    cpol = m3;
    sck <= m3;
    #HALF;
    cs_n <= 1'b0;
    #HALF;
  endtask
  task automatic desel();
    #HALF;
    cs_n <= 1'b1;
    #HALF;
  endtask
  // pause entered and left with the clock low, clock wiggled meanwhile
  task automatic pause();
    #20;
    hold_n <= 1'b0;
    repeat (3)
    begin
      #HALF;
      sck <= 1'b1;
      si <= ~si;
      #HALF;
      sck <= 1'b0;
    end
    #20;
    hold_n <= 1'b1;
    #20;
  endtask
  task automatic xfer(input byte_t tx, input int hp, output byte_t rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck <= 1'b0;
      if (i == hp)
        pause();
      si <= tx[i];
      #HALF;
      rx[i] = q;
      sck <= 1'b1;
      #HALF;
    end
    if (!cpol)
      sck <= 1'b0;
  endtask
endmodule
`default_nettype wire
